/* File: inc/lifetime_counter_pkg.sv */
// types of the lifetime counter
package lifetime_counter_pkg;

	// which half of a split count read is still owed
	typedef enum logic [1:0] {
		READ_IDLE = 2'b00,
		READ_OWE_LOW = 2'b01,
		READ_OWE_HIGH = 2'b10
	} split_read_type;

endpackage : lifetime_counter_pkg

/* File: inc/lifetime_counter_regs.svh */
// register map, field positions and reset values of the lifetime counter
`ifndef LIFETIME_COUNTER_REGS_SVH
`define LIFETIME_COUNTER_REGS_SVH

// word indices of the register window bases
`define LTM_BASE_BLOCKING 12'hE00
`define LTM_BASE_NONBLOCKING 12'hF00

// register indices inside the window
`define LTM_IDX_CONTROL 12'h038
`define LTM_IDX_STATUS 12'h03A
`define LTM_IDX_RESERVED 12'h03B
`define LTM_IDX_COUNT_HIGH 12'h03C
`define LTM_IDX_COUNT_LOW 12'h03E

// control register fields
`define LTM_CTL_IRQ_ENABLE_MASK_BIT 15
`define LTM_CTL_COUNT_ENABLE_MASK_BIT 8
`define LTM_CTL_IRQ_ENABLE_BIT 7
`define LTM_CTL_COUNT_ENABLE_BIT 0

// status register fields
`define LTM_SR_OVERFLOW_BIT 7

// count reset value and the all-ones value that overflows
`define LTM_COUNT_RESET 32'h0000_0000
`define LTM_COUNT_ALL_ONES 32'hFFFF_FFFF

// byte lanes that make up one 16-bit word
`define LTM_HALF_STROBE 4'h3

`endif

/* File: rtl/lifetime_counter.sv */
// lifetime counter: 32-bit up counter on the slow aux clock behind an apb slave
`timescale 1ns/1ps
`default_nettype none
`include "lifetime_counter_regs.svh"

module lifetime_counter #(
	parameter int COUNT_WIDTH = 32,
	parameter int ADDR_WIDTH = 16
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic slowAuxClock,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_WIDTH-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic overflowIrq,
	output logic overflowWake
);

	localparam int HALF = COUNT_WIDTH / 2;

	// slow clock synchroniser and edge detect
	logic auxSync1_q;
	logic auxSync2_q;
	logic auxSync3_q;
	logic auxTick;

	// control, status and count state
	logic countEnable_q;
	logic irqEnable_q;
	logic overflowFlag_q;
	logic [COUNT_WIDTH-1:0] count_q;
	logic [COUNT_WIDTH-1:0] count_d;
	lifetime_counter_pkg::split_read_type splitRead_q;
	lifetime_counter_pkg::split_read_type splitRead_d;

	// bus response registers
	logic respValid_q;
	logic [31:0] prdata_q;
	logic pslverr_q;
	logic respValid_d;
	logic [31:0] prdata_d;
	logic pslverr_d;

	// next values of control and flag, output flops
	logic countEnable_d;
	logic irqEnable_d;
	logic overflowFlag_d;
	logic overflowIrq_q;
	logic overflowWake_q;

	// index decode
	function automatic logic hitIndex(input logic [ADDR_WIDTH-1:0] addr, input logic [11:0] idx);
		logic [ADDR_WIDTH-1:0] blockAddr;
		logic [ADDR_WIDTH-1:0] freeAddr;
		blockAddr = ADDR_WIDTH'({`LTM_BASE_BLOCKING + idx, 2'b00});
		freeAddr = ADDR_WIDTH'({`LTM_BASE_NONBLOCKING + idx, 2'b00});
		hitIndex = (addr == blockAddr) || (addr == freeAddr);
	endfunction : hitIndex

	wire hitControl = hitIndex(paddr, `LTM_IDX_CONTROL);
	wire hitStatus = hitIndex(paddr, `LTM_IDX_STATUS);
	wire hitReserved = hitIndex(paddr, `LTM_IDX_RESERVED);
	wire hitHigh = hitIndex(paddr, `LTM_IDX_COUNT_HIGH);
	wire hitLow = hitIndex(paddr, `LTM_IDX_COUNT_LOW);
	wire hitAny = hitControl | hitStatus | hitReserved | hitHigh | hitLow;

	wire setupPhase = psel & ~penable;
	wire accessDone = psel & penable & pready;
	wire halfWord = (pstrb[1:0] == 2'(`LTM_HALF_STROBE));
	wire wideReg = hitControl | hitHigh | hitLow;
	wire unmapped = ~hitAny;
	wire partialWrite = pwrite & wideReg & ~halfWord;
	wire badAccess = unmapped | partialWrite;
	wire writeOk = accessDone & pwrite & ~pslverr_q;

	wire writeControl = writeOk & hitControl;
	wire writeStatus = writeOk & hitStatus;
	wire writeHigh = writeOk & hitHigh;
	wire writeLow = writeOk & hitLow;

	wire readHigh = setupPhase & ~pwrite & hitHigh;
	wire readLow = setupPhase & ~pwrite & hitLow;

	// write data fields
	wire countEnableMask = pwdata[`LTM_CTL_COUNT_ENABLE_MASK_BIT];
	wire countEnableValue = pwdata[`LTM_CTL_COUNT_ENABLE_BIT];
	wire irqEnableMask = pwdata[`LTM_CTL_IRQ_ENABLE_MASK_BIT];
	wire irqEnableValue = pwdata[`LTM_CTL_IRQ_ENABLE_BIT];
	wire clearRequest = pwdata[`LTM_SR_OVERFLOW_BIT];
	wire clearFlag = writeStatus & clearRequest;

	// counter stopped while half a split read is owed
	wire halfOwed = (splitRead_q != lifetime_counter_pkg::READ_IDLE);
	wire frozen = halfOwed | readHigh | readLow;
	wire stepCount = auxTick & countEnable_q & ~frozen;
	wire overflowEvent = stepCount & (count_q == `LTM_COUNT_ALL_ONES);
	wire [COUNT_WIDTH-1:0] countStepped = count_q + COUNT_WIDTH'(1);

	wire [15:0] controlRead = {8'h00, irqEnable_q, 6'h00, countEnable_q};
	wire [7:0] statusRead = {overflowFlag_q, 7'h00};

	wire [31:0] controlWord = {16'h0000, controlRead};
	wire [31:0] statusWord = {24'h00_0000, statusRead};
	wire [31:0] highWord = {16'h0000, count_q[COUNT_WIDTH-1 -: HALF]};
	wire [31:0] lowWord = {16'h0000, count_q[HALF-1:0]};

	wire [31:0] readMux =
		hitControl ? controlWord :
		hitStatus ? statusWord :
		hitHigh ? highWord :
		hitLow ? lowWord :
		32'h0000_0000;

	// split read tracking
	always_comb begin
		splitRead_d = splitRead_q;
		case (splitRead_q)
			lifetime_counter_pkg::READ_IDLE: begin
				if (readHigh) begin
					splitRead_d = lifetime_counter_pkg::READ_OWE_LOW;
				end else if (readLow) begin
					splitRead_d = lifetime_counter_pkg::READ_OWE_HIGH;
				end
			end
			lifetime_counter_pkg::READ_OWE_LOW: begin
				if (readLow) begin
					splitRead_d = lifetime_counter_pkg::READ_IDLE;
				end
			end
			lifetime_counter_pkg::READ_OWE_HIGH: begin
				if (readHigh) begin
					splitRead_d = lifetime_counter_pkg::READ_IDLE;
				end
			end
			default: begin
				splitRead_d = lifetime_counter_pkg::READ_IDLE;
			end
		endcase
	end

	// count next value
	always_comb begin
		count_d = count_q;
		if (stepCount) begin
			count_d = countStepped;
		end
		if (writeHigh) begin
			count_d[COUNT_WIDTH-1 -: HALF] = pwdata[HALF-1:0];
		end
		if (writeLow) begin
			count_d[HALF-1:0] = pwdata[HALF-1:0];
		end
	end

	// two flop synchroniser for the slow clock
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			auxSync1_q <= 1'b0;
			auxSync2_q <= 1'b0;
		end else begin
			auxSync1_q <= slowAuxClock;
			auxSync2_q <= auxSync1_q;
		end
	end

	// rising edge of the synchronised slow clock
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			auxSync3_q <= 1'b0;
		end else begin
			auxSync3_q <= auxSync2_q;
		end
	end

	assign auxTick = auxSync2_q & ~auxSync3_q;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			count_q <= `LTM_COUNT_RESET;
		end else begin
			count_q <= count_d;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			splitRead_q <= lifetime_counter_pkg::READ_IDLE;
		end else begin
			splitRead_q <= splitRead_d;
		end
	end

	// enable bits, each written only with its own mask bit set
	always_comb begin
		countEnable_d = countEnable_q;
		irqEnable_d = irqEnable_q;
		if (writeControl && countEnableMask) begin
			countEnable_d = countEnableValue;
		end
		if (writeControl && irqEnableMask) begin
			irqEnable_d = irqEnableValue;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			countEnable_q <= 1'b0;
		end else begin
			countEnable_q <= countEnable_d;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irqEnable_q <= 1'b0;
		end else begin
			irqEnable_q <= irqEnable_d;
		end
	end

	// overflow flag, set wins over clear
	always_comb begin
		overflowFlag_d = overflowFlag_q;
		if (overflowEvent) begin
			overflowFlag_d = 1'b1;
		end else if (clearFlag) begin
			overflowFlag_d = 1'b0;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			overflowFlag_q <= 1'b0;
		end else begin
			overflowFlag_q <= overflowFlag_d;
		end
	end

	// irq and wake from flops, in step with the flag
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			overflowIrq_q <= 1'b0;
		end else begin
			overflowIrq_q <= overflowFlag_d & irqEnable_d;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			overflowWake_q <= 1'b0;
		end else begin
			overflowWake_q <= overflowFlag_d;
		end
	end

	// apb response, data captured in the setup cycle
	always_comb begin
		respValid_d = respValid_q;
		prdata_d = prdata_q;
		pslverr_d = pslverr_q;
		if (setupPhase) begin
			respValid_d = 1'b1;
			prdata_d = pwrite ? 32'h0000_0000 : readMux;
			pslverr_d = badAccess;
		end else if (accessDone) begin
			respValid_d = 1'b0;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			respValid_q <= 1'b0;
		end else begin
			respValid_q <= respValid_d;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else begin
			prdata_q <= prdata_d;
			pslverr_q <= pslverr_d;
		end
	end

	assign pready = psel & penable & respValid_q;
	assign prdata = prdata_q;
	assign pslverr = pslverr_q & pready;
	assign overflowIrq = overflowIrq_q;
	assign overflowWake = overflowWake_q;

endmodule : lifetime_counter

`default_nettype wire

/* File: verification/lifetime_counter_chk.sv */
// port assertions of the lifetime counter
`timescale 1ns/1ps
`default_nettype none
module lifetime_counter_chk (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic overflowIrq,
	input wire logic overflowWake
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	wire logic stWr = pready && pwrite && paddr == 16'h38E8;
	irq_needs_flag_a: assert property (overflowIrq |-> overflowWake)
		else $error("irq without flag");
	zero_wait_a: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	flag_keep_a: assert property (stWr && !pwdata[7] && overflowWake |=> overflowWake)
		else $error("flag lost on zero write");
	flag_clear_a: assert property (stWr && pwdata[7] |=> !overflowWake)
		else $error("flag not cleared");
	half_word_a: assert property (pready && pwrite && paddr[7:0] == 8'hF8 && pstrb[1:0] != 2'h3 |-> pslverr)
		else $error("partial count write accepted");
	reserved_zero_a: assert property (pready && !pwrite && paddr == 16'h38EC |-> prdata == 32'h0 && !pslverr)
		else $error("reserved read not zero");
	status_read_a: assert property (pready && !pwrite && paddr == 16'h38E8 |-> prdata == {24'h0, $past(overflowWake), 7'h0})
		else $error("status read wrong");
	count_ok_a: assert property (pready && paddr[7:0] == 8'hF0 && pstrb == 4'hF |-> !pslverr)
		else $error("count access refused");
endmodule : lifetime_counter_chk
`default_nettype wire

/* File: verification/test_lifetime_counter.sv */
// testbench of the lifetime counter
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module test_lifetime_counter;
	logic core_clk, rst, slowAuxClock, psel, penable, pwrite;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb;
	logic pready, pslverr, overflowIrq, overflowWake;
	logic [32:0] expQ[$];
	logic [32:0] expNow;
	int error_cnt, checks, r;
	lifetime_counter DUT (.core_clk, .rst, .slowAuxClock, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb, .prdata, .pready, .pslverr, .overflowIrq, .overflowWake);
	initial begin
		core_clk = 0;
		forever #10 core_clk = ~core_clk;
	end
	task automatic stop_test;
		if (error_cnt == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : stop_test
	// results checked in order of issue
	always @(posedge core_clk) if (psel && penable && pready) begin
		expNow = expQ.pop_front();
		`CHK({pslverr, pwrite ? 32'h0 : prdata}, expNow)
	end
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
			input logic [3:0] s, input logic [32:0] e);
		int n;
		expQ.push_back(e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			error_cnt++;
			stop_test();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask : apb
	task automatic rd(input logic [15:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0, 4'hF, {1'b0, e});
	endtask : rd
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 4'hF, 33'h0);
	endtask : wr
	task automatic pulse;
		slowAuxClock <= 1'b1;
		repeat (2) @(posedge core_clk);
		slowAuxClock <= 1'b0;
		repeat (4) @(posedge core_clk);
	endtask : pulse
	initial begin
		rst <= 1'b1;
		{slowAuxClock, psel, penable, pwrite, paddr, pwdata, pstrb} <= '0;
		error_cnt = 0;
		checks = 0;
		r = $urandom(32'h3FC7FB88);
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		rd(16'h38F0, 32'h0);
		rd(16'h38F8, 32'h0);
		rd(16'h38E8, 32'h0);
		rd(16'h38EC, 32'h0);
		apb(1'b0, 16'h38E4, 32'h0, 4'hF, {1'b1, 32'h0});
		wr(16'h38E0, 32'h0081);
		rd(16'h38E0, 32'h0);
		wr(16'h3CE0, 32'h8080);
		rd(16'h38E0, 32'h0080);
		r = $urandom % 4;
		wr(16'h3CF0, 32'h0000FFFF);
		apb(1'b1, 16'h3CF8, 32'h1234, 4'h1, {1'b1, 32'h0});
		wr(16'h3CF8, 32'h0000FFFF - r);
		rd(16'h38F8, 32'h0000FFFF - r);
		rd(16'h38F0, 32'h0000FFFF);
		wr(16'h38E0, 32'h0101);
		repeat (r + 1) pulse();
		`CHK(overflowIrq, 1'b1)
		`CHK(overflowWake, 1'b1)
		rd(16'h38E8, 32'h80);
		rd(16'h38F0, 32'h0);
		repeat (3) pulse();
		rd(16'h38F8, 32'h0);
		pulse();
		rd(16'h38F8, 32'h1);
		rd(16'h38F0, 32'h0);
		wr(16'h38E8, 32'h0);
		rd(16'h38E8, 32'h80);
		wr(16'h38E0, 32'h8000);
		`CHK(overflowIrq, 1'b0)
		wr(16'h38E8, 32'h80);
		rd(16'h38E8, 32'h0);
		stop_test();
	end
endmodule : test_lifetime_counter
bind lifetime_counter lifetime_counter_chk chk (.core_clk, .rst, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .overflowIrq, .overflowWake);
`default_nettype wire
